// file: hdl/dbc_pkg.sv
// Package of constants and types for the delayed branch control block
package dbc_pkg;
    localparam int        PC_W          = 32;
    localparam int        LVL_W         = 5;
    localparam int        CCR_W         = 8;
    localparam int        CCR_IE_BIT    = 4;
    localparam logic [4:0] ILM_RESET    = 5'h0f;
    localparam logic [PC_W-1:0] PC_RESET = 32'h00000000;
    localparam logic [PC_W-1:0] PC_STEP  = 32'h00000002;
    localparam int        TAKEN_CYCLES  = 2;
    localparam int        FALL_CYCLES   = 1;
    localparam int        USER_LEVELS   = 15;

    // Branch kinds presented by the decoder
    typedef enum logic [2:0] {
        DBC_BR_NONE,
        DBC_BR_COND,
        DBC_BR_JUMP,
        DBC_BR_CALL,
        DBC_BR_CALLREG,
        DBC_BR_RET,
        DBC_BR_RETURN_FROM_EVENT_INSTRUCTION
    } dbc_brkind_e;

    // Event causes
    typedef enum logic [3:0] {
        DBC_EV_NONE,
        DBC_EV_RESET,
        DBC_EV_USERINT,
        DBC_EV_NMI,
        DBC_EV_DELAYINT,
        DBC_EV_UNDEF,
        DBC_EV_TRAP_INT,
        DBC_EV_TRAP_EMU,
        DBC_EV_STEP,
        DBC_EV_COPNONE,
        DBC_EV_COPERR
    } dbc_cause_e;

    // One decoded instruction from the stream
    typedef struct packed {
        logic              valid;
        logic [PC_W-1:0]   pc;
        dbc_brkind_e       kind;
        logic              delayed;
        logic              condTrue;
        logic [PC_W-1:0]   target;
        logic [PC_W-1:0]   regOperand;
        logic              undefined;
        logic              trapInt;
        logic              trapEmu;
        logic              copNone;
        logic              copErr;
        logic              writesRp;
        logic [PC_W-1:0]   rpWrData;
    } dbc_instr_s;

    // Asynchronous event requests
    typedef struct packed {
        logic              userInt;
        logic [LVL_W-1:0]  userLevel;
        logic              nmi;
        logic              delayInt;
        logic [LVL_W-1:0]  delayLevel;
        logic              stepTrace;
    } dbc_req_s;

    // Event taken by the core
    typedef struct packed {
        logic              take;
        dbc_cause_e        cause;
        logic [PC_W-1:0]   resumePc;
    } dbc_event_s;
endpackage

// file: hdl/dbc_event_sel.sv
// Event priority selector with level masking
`timescale 1ns/100ps
module dbc_event_sel
    import dbc_pkg::*;
(
    input  wire logic             intEnable,
    input  wire logic [LVL_W-1:0] maskLevel,
    input  wire logic             boundaryOk,
    input  wire dbc_req_s         req,
    input  wire logic             undefOk,
    input  wire logic             trapInt,
    input  wire logic             trapEmu,
    input  wire logic             copNone,
    input  wire logic             copErr,
    output logic                  sel,
    output dbc_cause_e            cause,
    output logic                  resumeNext
);
    localparam logic [LVL_W-1:0] NMI_LEVEL = 5'h0f;

    wire nmiOk   = req.nmi && (NMI_LEVEL < maskLevel) && boundaryOk;        // RL20
    wire userOk  = req.userInt && intEnable && (req.userLevel < maskLevel)
                   && boundaryOk;                                            // RL21
    wire delayOk = req.delayInt && intEnable && (req.delayLevel < maskLevel)
                   && boundaryOk;
    wire stepOk  = req.stepTrace && boundaryOk;                              // RL9

    always_comb begin
        sel        = 1'b1;
        resumeNext = 1'b1;
        cause      = DBC_EV_NONE;
        if (undefOk) begin
            cause      = DBC_EV_UNDEF;
            resumeNext = 1'b0;                                               // RL15
        end else if (copNone) begin
            cause = DBC_EV_COPNONE;                                          // RL16
        end else if (copErr) begin
            cause = DBC_EV_COPERR;
        end else if (trapInt) begin
            cause = DBC_EV_TRAP_INT;
        end else if (trapEmu) begin
            cause = DBC_EV_TRAP_EMU;
        end else if (nmiOk) begin
            cause = DBC_EV_NMI;
        end else if (delayOk) begin
            cause = DBC_EV_DELAYINT;
        end else if (userOk) begin
            cause = DBC_EV_USERINT;
        end else if (stepOk) begin
            cause = DBC_EV_STEP;
        end else begin
            sel = 1'b0;
        end
    end
endmodule

// file: hdl/dbc_branch_ctrl.sv
// Delayed and non-delayed branch sequencing with event entry and return
// Contract
// RL1: A delayed branch runs the next instruction before moving to its target.
// RL2: A delayed conditional branch always runs its slot instruction.
// RL3: Only the PC update is deferred; register effects stay in program order.
// RL4: Delayed register jumps and calls use the register value before the slot.
// RL5: A delayed return uses the return pointer held before the slot.
// RL6: A delayed conditional branch decides on flags from before the slot.
// RL7: A slot reading the return pointer after a delayed call sees the new value.
// RL8: Programs put only one-cycle, non-branch, order-safe instructions in slots.
// RL9: No step trace is raised between a delayed branch and its slot.
// RL10: No interrupt or NMI is accepted between a delayed branch and its slot.
// RL11: An undefined opcode in a slot acts as a no-operation.
// RL12: Non-delayed branches keep strict program order.
// RL13: Non-delayed branch takes two cycles taken, one cycle not taken.
// RL14: Programs fill an unusable slot with a no-operation.
// RL15: After an exception, execution resumes at the faulting instruction.
// RL16: After a trap, execution resumes at the following instruction.
// RL17: Reset, interrupts, NMI, delayed interrupt, undefined, traps are recognised.
// RL18: Handlers return only through the return-from-event instruction.
// RL19: Nested interrupts and fifteen usable mask levels are supported.
// RL20: A request at or above the mask level is refused.
// RL21: Interrupt enable is bit 4 of the condition code field.
// RL22: Reset loads the interrupt level mask with fifteen.
// RL23: A taken non-delayed branch discards the fetched sequential instruction.
`timescale 1ns/100ps
module dbc_branch_ctrl
    import dbc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire dbc_instr_s       instr,
    input  wire dbc_req_s         reqPins,
    input  wire logic [CCR_W-1:0] ccrIn,
    input  wire logic             ilmWrite,
    input  wire logic [LVL_W-1:0] ilmWrData,
    input  wire logic [PC_W-1:0]  eventVector,
    input  wire logic [PC_W-1:0]  savedPc,
    input  wire logic [LVL_W-1:0] savedIlm,
    output logic                  commit,
    output logic                  squash,
    output logic                  stall,
    output logic [PC_W-1:0]       fetchPc,
    output logic                  fetchRedirect,
    output logic [PC_W-1:0]       returnPtr,
    output logic [LVL_W-1:0]      ilmOut,
    output logic                  inSlot,
    output dbc_event_s            evOut,
    output logic [3:0]            nestDepth
);
    typedef enum logic [1:0] {S_RUN, S_SLOT, S_BUBBLE} dbc_state_e;

    dbc_state_e       state_ff, nxt_state;
    logic [PC_W-1:0]  pendTarget_ff;
    logic             pendTaken_ff;
    logic [PC_W-1:0]  rp_ff;
    logic [LVL_W-1:0] ilm_ff;
    logic             commit_ff, squash_ff, stall_ff, redirect_ff;
    logic [PC_W-1:0]  fetchPc_ff;
    dbc_event_s       ev_ff;
    logic [3:0]       nest_ff;
    dbc_req_s         reqMeta_ff, reqSync_ff;

    initial begin
        if (USER_LEVELS != 15) $error("dbc_branch_ctrl: level count mismatch");
    end

    // Two-stage capture of the outside event requests
    always_ff @(posedge clk) begin
        reqMeta_ff <= reqPins;
        reqSync_ff <= reqMeta_ff;
    end

    wire inRun    = state_ff == S_RUN;
    wire inSlotSt = state_ff == S_SLOT;
    wire isBranch = instr.valid && instr.kind != DBC_BR_NONE && instr.kind != DBC_BR_RETURN_FROM_EVENT_INSTRUCTION;
    wire isReti   = instr.valid && instr.kind == DBC_BR_RETURN_FROM_EVENT_INSTRUCTION && inRun;
    // Flags and register operand are the values present before the slot
    wire takenNow = isBranch && (instr.kind != DBC_BR_COND || instr.condTrue); // RL6
    wire [PC_W-1:0] brTarget =
        (instr.kind == DBC_BR_JUMP || instr.kind == DBC_BR_CALLREG) ? instr.regOperand : // RL4
        (instr.kind == DBC_BR_RET) ? rp_ff : instr.target;                           // RL5
    wire isCall    = instr.kind == DBC_BR_CALL || instr.kind == DBC_BR_CALLREG;
    wire delayedBr = isBranch && instr.delayed && inRun;
    wire plainBr   = isBranch && !instr.delayed && inRun;

    // Slot instruction: undefined acts as NOP, events held off until after the pair
    wire slotUndefNop = inSlotSt && instr.undefined;                          // RL11
    wire boundaryOk   = inRun && !delayedBr;                                  // RL10
    wire undefExc     = instr.valid && instr.undefined && inRun;
    wire evSel;
    dbc_cause_e evCause;
    wire evResumeNext;

    dbc_event_sel u_sel (
        .intEnable  (ccrIn[CCR_IE_BIT]),                                      // RL21
        .maskLevel  (ilm_ff),
        .boundaryOk (boundaryOk),
        .req        (reqSync_ff),
        .undefOk    (undefExc),
        .trapInt    (instr.valid && instr.trapInt && inRun),
        .trapEmu    (instr.valid && instr.trapEmu && inRun),
        .copNone    (instr.valid && instr.copNone && inRun),
        .copErr     (instr.valid && instr.copErr && inRun),
        .sel        (evSel),
        .cause      (evCause),
        .resumeNext (evResumeNext)
    );

    wire [PC_W-1:0] seqPc    = instr.pc + PC_STEP;
    wire [PC_W-1:0] resumePc = evResumeNext ? seqPc : instr.pc;               // RL16
    wire isInterrupt = evCause == DBC_EV_NMI || evCause == DBC_EV_USERINT
                       || evCause == DBC_EV_DELAYINT;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            S_RUN: begin
                if (evSel)
                    nxt_state = S_RUN;
                else if (delayedBr)
                    nxt_state = S_SLOT;                                       // RL1
                else if (plainBr && takenNow)
                    nxt_state = S_BUBBLE;                                     // RL13
            end
            S_SLOT:   if (instr.valid) nxt_state = S_RUN;                     // RL2
            S_BUBBLE: nxt_state = S_RUN;
            default:  nxt_state = S_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_ff      <= S_RUN;
            pendTarget_ff <= PC_RESET;
            pendTaken_ff  <= 1'b0;
            rp_ff         <= PC_RESET;
            ilm_ff        <= ILM_RESET;                                       // RL22
            commit_ff     <= 1'b0;
            squash_ff     <= 1'b0;
            stall_ff      <= 1'b0;
            redirect_ff   <= 1'b0;
            fetchPc_ff    <= PC_RESET;
            ev_ff         <= '0;
            nest_ff       <= 4'h0;
        end else begin
            state_ff    <= nxt_state;
            commit_ff   <= 1'b0;
            squash_ff   <= 1'b0;
            stall_ff    <= 1'b0;
            redirect_ff <= 1'b0;
            ev_ff       <= '0;
            if (inRun && instr.valid && evSel) begin
                ev_ff       <= '{take: 1'b1, cause: evCause, resumePc: resumePc}; // RL17
                redirect_ff <= 1'b1;
                fetchPc_ff  <= eventVector;
                if (isInterrupt && nest_ff != 4'hf)
                    nest_ff <= nest_ff + 4'h1;                                // RL19
                commit_ff   <= evResumeNext;                                  // RL15
            end else if (isReti) begin
                commit_ff   <= 1'b1;                                          // RL18
                redirect_ff <= 1'b1;
                fetchPc_ff  <= savedPc;
                ilm_ff      <= savedIlm;
                if (nest_ff != 4'h0)
                    nest_ff <= nest_ff - 4'h1;
            end else if (delayedBr) begin
                commit_ff     <= 1'b1;
                pendTarget_ff <= brTarget;
                pendTaken_ff  <= takenNow;                                    // RL6
                if (isCall)
                    rp_ff <= seqPc + PC_STEP;                                 // RL7
            end else if (inSlotSt && instr.valid) begin
                commit_ff   <= !slotUndefNop;                                 // RL11
                redirect_ff <= pendTaken_ff;                                  // RL1
                if (pendTaken_ff)
                    fetchPc_ff <= pendTarget_ff;                              // RL2
                if (instr.writesRp)
                    rp_ff <= instr.rpWrData;                                  // RL3
            end else if (plainBr) begin
                commit_ff <= 1'b1;                                            // RL12
                if (isCall && takenNow)
                    rp_ff <= seqPc;
                if (takenNow) begin
                    stall_ff    <= 1'b1;                                      // RL13
                    redirect_ff <= 1'b1;
                    fetchPc_ff  <= brTarget;
                end
            end else if (state_ff == S_BUBBLE) begin
                squash_ff <= instr.valid;                                     // RL23
            end else if (inRun && instr.valid) begin
                commit_ff <= 1'b1;
                if (instr.writesRp)
                    rp_ff <= instr.rpWrData;
                if (ilmWrite)
                    ilm_ff <= (ilm_ff[4] && !ilmWrData[4]) ?
                              (ilmWrData | 5'h10) : ilmWrData;
            end
        end
    end

    always_comb begin
        commit        = commit_ff;
        squash        = squash_ff;
        stall         = stall_ff;
        fetchPc       = fetchPc_ff;
        fetchRedirect = redirect_ff;
        returnPtr     = rp_ff;
        ilmOut        = ilm_ff;
        inSlot        = state_ff == S_SLOT;
        evOut         = ev_ff;
        nestDepth     = nest_ff;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_delayed_issue;
        delayedBr && !evSel;
    endsequence

    sequence s_slot_done;
        inSlotSt && instr.valid;
    endsequence

    chk_slot_follows: assert property (s_delayed_issue |=> inSlotSt) // RL1
        else $error("delayed branch did not enter slot");
    chk_slot_redirect: assert property (s_slot_done ##0 pendTaken_ff |=> fetchRedirect
        && fetchPc == $past(pendTarget_ff)) // RL2
        else $error("slot did not redirect to pending target");
    chk_slot_fall: assert property (s_slot_done ##0 !pendTaken_ff |=> !fetchRedirect) // RL2
        else $error("untaken delayed branch redirected");
    chk_no_event_slot: assert property (inSlotSt |=> !evOut.take) // RL10
        else $error("event accepted inside slot");
    chk_no_step_slot: assert property (inSlotSt && reqSync_ff.stepTrace |=> evOut.cause
        != DBC_EV_STEP) // RL9
        else $error("step trace inside slot");
    chk_undef_nop: assert property (inSlotSt && instr.valid && instr.undefined |=> !commit
        && !evOut.take) // RL11
        else $error("undefined slot not a no-op");
    chk_plain_bubble: assert property (plainBr && takenNow && !evSel |=> stall
        ##1 (state_ff == S_RUN)) // RL13
        else $error("taken plain branch timing wrong");
    chk_bubble_squash: assert property (state_ff == S_BUBBLE && instr.valid |=> squash
        && !commit) // RL23
        else $error("sequential instruction not discarded");
    chk_exc_resume: assert property (inRun && instr.valid && evSel
        && evCause == DBC_EV_UNDEF |=> evOut.resumePc == $past(instr.pc)) // RL15
        else $error("exception resume address wrong");
    chk_mask_level: assert property (evOut.take && evOut.cause == DBC_EV_USERINT
        |-> $past(reqSync_ff.userLevel) < $past(ilm_ff)) // RL20
        else $error("masked interrupt accepted");
    chk_call_rp: assert property (delayedBr && isCall && !evSel |=> returnPtr
        == $past(instr.pc) + 32'h00000004) // RL7
        else $error("delayed call return pointer wrong");
endmodule

// file: sim/dbc_stream_model.sv
// Instruction stream and event request source facing the branch control block
`timescale 1ns/100ps
module dbc_stream_model
    import dbc_pkg::*;
(
    input  wire logic clk,
    output dbc_instr_s instr,
    output dbc_req_s   reqPins
);
    initial begin
        instr   = '0;
        reqPins = '0;
    end

    // Presents one instruction; a delay slot gets one-cycle non-branch code or a no-op
    task automatic send(input dbc_instr_s i);
        @(posedge clk);
        instr <= i;
    endtask

    // Stream not presenting: fields no longer hold the last value
    task automatic idle();
        dbc_instr_s t;
        @(posedge clk);
        t = ~instr;
        t.valid = 1'b0;
        instr <= t;
    endtask

    task automatic request(input dbc_req_s r);
        @(posedge clk);
        reqPins <= r;
    endtask
endmodule

// file: sim/delayed_branch_control_tb_top.sv
// Self-checking bench for the delayed branch control block
`timescale 1ns/100ps
module delayed_branch_control_tb_top
    import dbc_pkg::*;
;
    logic             clk = 1'b0;
    logic             resetn = 1'b0;
    logic [CCR_W-1:0] ccrIn = 8'h10;
    logic             ilmWrite = 1'b0;
    logic [LVL_W-1:0] ilmWrData = 5'h00;
    logic [PC_W-1:0]  savedPc = 32'h00000a00;
    dbc_instr_s       instr;
    dbc_req_s         reqPins;
    logic             commit, squash, stall, fetchRedirect, inSlot;
    logic [PC_W-1:0]  fetchPc, returnPtr;
    logic [LVL_W-1:0] ilmOut;
    logic [3:0]       nestDepth;
    dbc_event_s       evOut;
    int               n_mismatch = 0;
    int               n_tests = 0;

    always #5 clk = ~clk;

    dbc_stream_model src (.clk(clk), .instr(instr), .reqPins(reqPins));

    dbc_branch_ctrl uut (
        .clk(clk), .resetn(resetn), .instr(instr), .reqPins(reqPins), .ccrIn(ccrIn),
        .ilmWrite(ilmWrite), .ilmWrData(ilmWrData), .eventVector(32'h00001000),
        .savedPc(savedPc), .savedIlm(5'h1f), .commit(commit), .squash(squash),
        .stall(stall), .fetchPc(fetchPc), .fetchRedirect(fetchRedirect),
        .returnPtr(returnPtr), .ilmOut(ilmOut), .inSlot(inSlot), .evOut(evOut),
        .nestDepth(nestDepth)
    );

    task automatic final_report();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic dbc_instr_s mk(input dbc_brkind_e k, input logic d,
                                      input logic [31:0] p, input logic [31:0] t);
        mk = '0;
        mk.valid = 1'b1;
        mk.kind = k;
        mk.delayed = d;
        mk.pc = p;
        mk.target = t;
        mk.regOperand = t;
        mk.condTrue = 1'b1;
    endfunction

    task automatic step_ilm(input logic w, input logic [4:0] v);
        fork
            src.send(mk(DBC_BR_NONE, 1'b0, 32'h100, 32'h0));
            begin
                @(posedge clk);
                ilmWrite <= w;
                ilmWrData <= v;
            end
        join
    endtask

    task automatic t_ilm(input logic [4:0] v, input logic [4:0] exp);
        step_ilm(1'b1, v);
        step_ilm(1'b0, v);
        #1;
        check(ilmOut, exp);
    endtask

    task automatic no_take();
        repeat (8) begin
            src.send(mk(DBC_BR_NONE, 1'b0, 32'h900, 32'h0));
            #1;
            check(evOut.take, 1'b0);
        end
    endtask

    task automatic wait_event(input dbc_cause_e c);
        int k;
        k = 0;
        do begin
            src.send(mk(DBC_BR_NONE, 1'b0, 32'h900, 32'h0));
            #1;
            k++;
        end while (evOut.take !== 1'b1 && k < 10);
        check(evOut.take, 1'b1);
        check(evOut.cause, c);
    endtask

    task automatic t_plain();
        dbc_instr_s c;
        src.send(mk(DBC_BR_COND, 1'b0, 32'h600, 32'h700));
        src.send(mk(DBC_BR_NONE, 1'b0, 32'h602, 32'h0));
        #1;
        check({commit, stall, fetchRedirect}, 3'h7);
        check(fetchPc, 32'h700);
        src.idle();
        #1;
        check({squash, commit}, 2'h2);
        c = mk(DBC_BR_COND, 1'b0, 32'h610, 32'h700);
        c.condTrue = 1'b0;
        src.send(c);
        src.idle();
        #1;
        check({commit, stall, fetchRedirect}, 3'h4);
    endtask

    task automatic t_cond(input logic tk, input logic und);
        dbc_instr_s b;
        dbc_instr_s s;
        b = mk(DBC_BR_COND, 1'b1, 32'h200, 32'h400);
        b.condTrue = tk;
        s = mk(DBC_BR_NONE, 1'b0, 32'h202, 32'h0);
        s.undefined = und;
        s.condTrue = ~tk;
        src.send(b);
        src.send(s);
        #1;
        check({commit, inSlot, fetchRedirect}, 3'h6);
        src.idle();
        #1;
        check({commit, fetchRedirect, evOut.take}, {~und, tk, 1'b0});
        if (tk) check(fetchPc, 32'h400);
    endtask

    task automatic t_call_ret();
        dbc_instr_s s;
        src.send(mk(DBC_BR_CALL, 1'b1, 32'h300, 32'h500));
        src.send(mk(DBC_BR_NONE, 1'b0, 32'h302, 32'h0));
        #1;
        check(returnPtr, 32'h304);
        src.idle();
        #1;
        check(fetchPc, 32'h500);
        s = mk(DBC_BR_NONE, 1'b0, 32'h502, 32'h0);
        s.writesRp = 1'b1;
        s.rpWrData = 32'h777;
        src.send(mk(DBC_BR_RET, 1'b1, 32'h500, 32'h0));
        src.send(s);
        src.idle();
        #1;
        check(fetchPc, 32'h304);
        check(returnPtr, 32'h777);
    endtask

    task automatic t_events();
        dbc_instr_s i;
        dbc_cause_e cs[5] = '{DBC_EV_UNDEF, DBC_EV_COPNONE, DBC_EV_COPERR,
                              DBC_EV_TRAP_INT, DBC_EV_TRAP_EMU};
        for (int n = 0; n < 5; n++) begin
            i = mk(DBC_BR_NONE, 1'b0, 32'h800, 32'h0);
            i.undefined = (n == 0);
            i.copNone = (n == 1);
            i.copErr = (n == 2);
            i.trapInt = (n == 3);
            i.trapEmu = (n == 4);
            src.send(i);
            src.idle();
            #1;
            check(evOut.take, 1'b1);
            check(evOut.cause, cs[n]);
            check(evOut.resumePc, (n == 0) ? 32'h800 : 32'h802);
            src.send(mk(DBC_BR_RETURN_FROM_EVENT_INSTRUCTION, 1'b0, 32'h1000, 32'h0));
            src.idle();
            #1;
            check(fetchRedirect, 1'b1);
            check(fetchPc, savedPc);
        end
    endtask

    task automatic t_irq_pair();
        fork
            src.request('{1'b1, 5'h14, 1'b0, 1'b0, 5'h00, 1'b0});
            src.send(mk(DBC_BR_JUMP, 1'b1, 32'h200, 32'h400));
        join
        src.send(mk(DBC_BR_NONE, 1'b0, 32'h202, 32'h999));
        #1;
        check({inSlot, evOut.take}, 2'h2);
        src.idle();
        #1;
        check(fetchPc, 32'h400);
        check(evOut.take, 1'b0);
        wait_event(DBC_EV_USERINT);
        check(nestDepth, 4'h1);
        src.request('0);
        src.send(mk(DBC_BR_RETURN_FROM_EVENT_INSTRUCTION, 1'b0, 32'h1000, 32'h0));
        src.idle();
    endtask

    task automatic t_mask();
        src.request('{1'b1, 5'h1f, 1'b0, 1'b0, 5'h00, 1'b0});
        no_take();
        @(posedge clk);
        ccrIn <= 8'h00;
        src.request('{1'b1, 5'h14, 1'b0, 1'b0, 5'h00, 1'b0});
        no_take();
        src.request('0);
        repeat (4) @(posedge clk);
        ccrIn <= 8'h10;
    endtask

    initial begin
        #20000;
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        #1;
        check(ilmOut, ILM_RESET);
        check({commit, evOut.take}, 2'h0);
        t_ilm(5'h1f, 5'h1f);
        t_ilm(5'h03, 5'h13);
        t_ilm(5'h1f, 5'h1f);
        t_plain();
        t_cond(1'b1, 1'b0);
        t_cond(1'b0, 1'b0);
        t_cond(1'b1, 1'b1);
        t_call_ret();
        t_events();
        t_mask();
        t_irq_pair();
        final_report();
    end
endmodule
